// ---- bench/pcs_decoder_model.sv ----
/*
 pcs_decoder_model: stands in for the instruction decoder and the
 interrupt logic. Assumes the bench sets kind and rnd on the clock.
*/
`timescale 1ns/10ps
module pcs_decoder_model
   import pcs_pkg::*;
(
   input wire logic [2:0] kind,
   input wire logic [31:0] rnd,
   output pcs_cmd_s cmd
);
   // one kind per cycle
   // never irq with ret: irq wins in pcs_top and the pop is refused
   always_comb begin
      cmd = '0;
      cmd.advance = rnd[0];
      cmd.low_data = rnd[15:8];
      cmd.latch_data = rnd[23:16];
      cmd.target = rnd[26:16];
      case (kind)
         3'h0: cmd.latch_write = rnd[1];
         3'h1: cmd.low_write = 1'b1;
         3'h2: cmd.call = 1'b1;
         3'h3: cmd.jump = 1'b1;
         3'h4: cmd.ret = 1'b1;
         3'h5: cmd.irq = 1'b1;
         default: ;
      endcase
   end
endmodule : pcs_decoder_model

// ---- bench/pcs_top_bench.sv ----
/*
 pcs_top_bench: random and corner stimulus against a reference model.
 Assumes the decoder model builds each command from kind and rnd.
*/
`timescale 1ns/10ps
module pcs_top_bench;
   import pcs_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b;
   logic [2:0] kind = 3'h0;
   logic [31:0] rnd = 32'h0;
   pcs_cmd_s cmd;
   logic [12:0] pc_addr;
   logic [7:0] pc_low_byte_reg;
   logic [7:0] pc_high_holding_latch;
   logic [12:0] exp_pc;
   logic [12:0] stk [8];
   logic [7:0] exp_latch;
   logic [2:0] sp;
   int err_count = 0;
   int samples_checked = 0;
   int seed = 29;
   int cycles = 0;

   initial forever #2.5 clk_sys = ~clk_sys;

   pcs_decoder_model u_pcs_decoder_model (.kind(kind), .rnd(rnd),
      .cmd(cmd));
   pcs_top u_pcs_top (.clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd),
      .pc_addr(pc_addr), .pc_low_byte_reg(pc_low_byte_reg),
      .pc_high_holding_latch(pc_high_holding_latch));

   function automatic logic [12:0] next_pc(pcs_cmd_s c, logic [12:0] pc,
      logic [12:0] top, logic [7:0] lt);
      if (c.irq) return INT_VECTOR;
      if (c.ret) return top;
      if (c.call || c.jump) return {lt[4:3], c.target};
      if (c.low_write) return {lt[4:0], c.low_data};
      if (c.advance) return pc + PC_ONE;
      return pc;
   endfunction : next_pc

   task automatic chk(string n, logic [12:0] e, logic [12:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   // outputs of the previous command are compared before the model moves
   task automatic step(logic [2:0] k, logic [31:0] r);
      logic [12:0] np;
      @(posedge clk_sys);
      kind <= k;
      rnd <= r;
      @(negedge clk_sys);
      chk("pc_addr", exp_pc, pc_addr);
      chk("low", {5'h00, exp_pc[7:0]}, {5'h00, pc_low_byte_reg});
      chk("latch", {5'h00, exp_latch}, {5'h00, pc_high_holding_latch});
      np = next_pc(cmd, exp_pc, stk[sp - SP_ONE], exp_latch);
      if (cmd.irq || (cmd.call && !cmd.ret)) begin
         stk[sp] = exp_pc;
         sp = sp + SP_ONE;
      end else if (cmd.ret) sp = sp - SP_ONE;
      exp_pc = np;
      if (cmd.latch_write) exp_latch = cmd.latch_data;
   endtask : step

   task automatic reset_dut;
      @(posedge clk_sys);
      rst_b <= 1'b0;
      kind <= 3'h0;
      rnd <= 32'h0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      exp_pc = PC_RESET;
      exp_latch = LATCH_RESET;
      sp = SP_RESET;
      foreach (stk[i]) stk[i] = PC_RESET;
   endtask : reset_dut

   // hang guard, about three times the expected run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 7000) begin
         err_count++;
         complete_run();
      end
   end

   initial begin
      // falling edge at time zero so no flop starts unknown
      rst_b <= 1'b0;
      reset_dut();
      // page bits set before the call
      step(3'h0, 32'h0008_0002);
      step(3'h2, 32'h0123_0000);
      step(3'h4, 32'h0000_0000);
      // nine pushes wrap, advance refused beside each call
      for (int i = 0; i < 9; i++) step(3'h2, (i << 20) | 32'h1);
      for (int i = 0; i < 9; i++) step(3'h4, 32'h1);
      step(3'h0, 32'h001F_0002);
      step(3'h1, 32'h0000_FF00);
      step(3'h0, 32'h0000_0001);
      step(3'h5, 32'h0000_0001);
      $display("corner tests done");
      repeat (2000) step(3'($unsigned($random(seed)) % 6), $random(seed));
      $display("random tests done");
      reset_dut();
      step(3'h0, 32'h0000_0000);
      $display("reset test done");
      complete_run();
   end
endmodule : pcs_top_bench

// ---- core/pcs_pkg.sv ----
/*
 pcs_pkg: constants and carrier types for the program counter and
 return stack. Assumes a single core clock domain.
*/
package pcs_pkg;
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int HIGH_W = 5;
   localparam int JUMP_W = 11;
   localparam int PAGE_LSB = 3;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] INT_VECTOR = 13'h0004;
   localparam logic [12:0] PC_ONE = 13'h0001;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [2:0] SP_RESET = 3'h0;
   localparam logic [2:0] SP_ONE = 3'h1;

   // one-hot-ish command from the decoder, one per core cycle
   typedef struct packed {
      logic advance;
      logic low_write;
      logic [7:0] low_data;
      logic latch_write;
      logic [7:0] latch_data;
      logic call;
      logic jump;
      logic [10:0] target;
      logic ret;
      logic irq;
   } pcs_cmd_s;
endpackage : pcs_pkg

// ---- core/pcs_stack.sv ----
/*
 pcs_stack: eight-entry circular return-address storage.
 Assumes push and pop are never asserted in the same cycle.
*/
`timescale 1ns/10ps
module pcs_stack
   import pcs_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [12:0] push_data,
   output logic [12:0] top_data
);
   logic [SP_W-1:0] sp_r;
   logic [SP_W-1:0] sp_nxt;
   logic [SP_W-1:0] top_idx;
   logic [12:0] mem_r [DEPTH];

   // pointer names the next free slot; wraps silently both ways
   assign top_idx = sp_r - SP_ONE;
   assign top_data = mem_r[top_idx];
   assign sp_nxt = push ? sp_r + SP_ONE : (pop ? top_idx : sp_r);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= SP_RESET;
      end else begin
         sp_r <= sp_nxt;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               mem_r[gi] <= PC_RESET;
            end else if (push && sp_r == SP_W'(gi)) begin
               mem_r[gi] <= push_data;
            end
         end
      end
   endgenerate

   ptr_wrap_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      push |=> sp_r == $past(sp_r) + SP_ONE)
      else $error("stack pointer did not advance on push");
endmodule : pcs_stack

// ---- core/pcs_top.sv ----
/*
 pcs_top: 13-bit program counter, low byte register, high holding
 latch and return stack. Assumes the decoder issues at most one of
 call, jump, ret, irq, low_write per cycle and never irq with call.
*/
`timescale 1ns/10ps
module pcs_top
   import pcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire pcs_cmd_s cmd,
   output logic [12:0] pc_addr,
   output logic [7:0] pc_low_byte_reg,
   output logic [7:0] pc_high_holding_latch
);
   logic rst_s1_r;
   logic rst_n;
   logic [12:0] pc_r;
   logic [12:0] pc_nxt;
   logic [7:0] latch_r;
   logic [7:0] latch_nxt;
   logic [12:0] pc_inc;
   logic [12:0] ret_addr;
   logic [12:0] low_load;
   logic [12:0] far_load;
   logic [12:0] pop_data;
   logic do_push;
   logic do_pop;
   logic no_load;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // wraps at top of 8K space
   assign pc_inc = pc_r + PC_ONE;
   // pc_r already points past the call/interrupted instruction
   assign ret_addr = pc_r;
   // full upper bits from latch on low write, only page bits 4:3 on call/jump; no carry into upper bits
   assign low_load = {latch_r[HIGH_W-1:0], cmd.low_data};
   assign far_load = {latch_r[HIGH_W-1:PAGE_LSB], cmd.target};
   // push sources; a refused call or return must not move the stack
   assign do_push = cmd.irq | (cmd.call & ~cmd.ret);
   assign do_pop = cmd.ret & ~cmd.irq;
   // no source but advance may move the counter
   assign no_load = ~(cmd.irq | cmd.ret | cmd.call | cmd.jump | cmd.low_write);
   assign latch_nxt = cmd.latch_write ? cmd.latch_data : latch_r;

   always_comb begin
      pc_nxt = pc_r;
      if (cmd.irq) begin
         pc_nxt = INT_VECTOR;
      end else if (cmd.ret) begin
         pc_nxt = pop_data;
      end else if (cmd.call || cmd.jump) begin
         pc_nxt = far_load;
      end else if (cmd.low_write) begin
         pc_nxt = low_load;
      end else if (cmd.advance) begin
         pc_nxt = pc_inc;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_r <= PC_RESET;
         latch_r <= LATCH_RESET;
      end else begin
         pc_r <= pc_nxt;
         latch_r <= latch_nxt;
      end
   end

   // upper bits only visible as address, never as a byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_addr <= PC_RESET;
         pc_low_byte_reg <= PC_RESET[LOW_W-1:0];
         pc_high_holding_latch <= LATCH_RESET;
      end else begin
         pc_addr <= pc_nxt;
         pc_low_byte_reg <= pc_nxt[LOW_W-1:0];
         pc_high_holding_latch <= latch_nxt;
      end
   end

   // pointer is internal, no flags leave the stack
   pcs_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .push(do_push),
      .pop(do_pop),
      .push_data(ret_addr),
      .top_data(pop_data)
   );

   // full 13-bit address, software owns page selection


   low_load_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.low_write && !cmd.irq && !cmd.ret && !cmd.call && !cmd.jump
      |=> pc_r == {$past(latch_r[4:0]), $past(cmd.low_data)})
      else $error("low byte write loaded wrong address");

   far_page_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (cmd.call || cmd.jump) && !cmd.irq && !cmd.ret
      |=> pc_r[12:11] == $past(latch_r[4:3])
          && pc_r[10:0] == $past(cmd.target))
      else $error("call or jump target wrong");

   irq_vector_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.irq |=> pc_r == 13'h0004)
      else $error("interrupt did not vector");

   call_ret_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.call && !cmd.irq && !cmd.ret ##1 (cmd.ret && !cmd.irq)
      |=> pc_r == $past(pc_r, 2))
      else $error("return did not restore address");

   latch_keep_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !cmd.latch_write |=> $stable(latch_r))
      else $error("holding latch changed without write");

   pc_wrap_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.advance && !cmd.irq && !cmd.ret && !cmd.call && !cmd.jump
      && !cmd.low_write |=> pc_r == $past(pc_r) + 13'h0001)
      else $error("increment wrong");

   pc_reset_a: assert property (
      @(posedge clk_sys)
      !rst_n |-> pc_r == 13'h0000 && pc_addr == 13'h0000)
      else $error("counter not cleared in reset");

   low_mirror_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pc_low_byte_reg == pc_r[7:0] && pc_addr == pc_r)
      else $error("low byte output out of step");

   rst_sync_a: assert property (
      @(posedge clk_sys)
      !rst_s1_r |=> !rst_n)
      else $error("internal reset released too early");

   out_reset_a: assert property (
      @(posedge clk_sys)
      !rst_n |-> pc_low_byte_reg == 8'h00 && pc_high_holding_latch == 8'h00)
      else $error("byte outputs not cleared in reset");

   stack_reset_a: assert property (
      @(posedge clk_sys)
      !rst_n |-> pop_data == 13'h0000)
      else $error("stack top not cleared in reset");

   pc_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      no_load && !cmd.advance |=> pc_r == $past(pc_r))
      else $error("counter moved with no command");

   upper_only_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      no_load && !(cmd.advance && pc_r[7:0] == 8'hFF)
      |=> pc_r[12:8] == $past(pc_r[12:8]))
      else $error("upper counter bits moved without a load");

   latch_mirror_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pc_high_holding_latch == latch_r)
      else $error("holding latch output out of step");

   latch_load_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.latch_write |=> latch_r == $past(cmd.latch_data))
      else $error("holding latch write lost");

   low_byte_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.low_write && !cmd.irq && !cmd.ret && !cmd.call && !cmd.jump
      |=> pc_low_byte_reg == $past(cmd.low_data))
      else $error("low byte output not the written value");

   low_upper_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.low_write && !cmd.irq && !cmd.ret && !cmd.call && !cmd.jump
      |=> pc_addr[12:8] == $past(pc_high_holding_latch[4:0]))
      else $error("upper bits not taken from latch on low write");

   far_upper_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (cmd.call || cmd.jump) && !cmd.irq && !cmd.ret
      |=> pc_addr[12:11] == $past(pc_high_holding_latch[4:3]))
      else $error("page bits not taken from latch");

   call_push_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.call && !cmd.irq && !cmd.ret |=> pop_data == $past(pc_r))
      else $error("call did not push return address");

   irq_push_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.irq |=> pop_data == $past(pc_r))
      else $error("interrupt did not push return address");

   jump_nopush_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.jump && !cmd.call && !cmd.irq && !cmd.ret
      |=> pop_data == $past(pop_data))
      else $error("jump moved the stack");

   ret_pop_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.ret && !cmd.irq |=> pc_r == $past(pop_data))
      else $error("return did not load stack top");

   irq_ret_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.irq ##1 (cmd.ret && !cmd.irq) |=> pc_r == $past(pc_r, 2))
      else $error("interrupt return did not restore address");

   ret_upper_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.call && !cmd.irq && !cmd.ret
      ##1 (cmd.latch_write && !cmd.call && !cmd.irq && !cmd.ret)
      ##1 (cmd.ret && !cmd.irq) |=> pc_r == $past(pc_r, 3))
      else $error("return took upper bits from the latch");

   ret_latch_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.ret && !cmd.latch_write
      |=> pc_high_holding_latch == $past(pc_high_holding_latch))
      else $error("return changed the holding latch");

   push_latch_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (cmd.call || cmd.irq) && !cmd.latch_write
      |=> pc_high_holding_latch == $past(pc_high_holding_latch))
      else $error("push changed the holding latch");

   inc_wrap_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.advance && no_load && pc_r == 13'h1FFF
      |=> pc_r == 13'h0000)
      else $error("increment did not wrap to zero");

   inc_carry_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cmd.advance && no_load && pc_r[7:0] == 8'hFF
      |=> pc_r[12:8] == $past(pc_r[12:8]) + 5'h01)
      else $error("increment did not carry into upper bits");

   call_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      cmd.call ##[1:20] cmd.ret);
   irq_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      cmd.irq ##[1:20] cmd.ret);
   wrap_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      pc_r == 13'h1FFF && cmd.advance);
   low_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      cmd.low_write);
   page_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      cmd.jump && latch_r[4:3] != 2'b00);
endmodule : pcs_top
